// [shared/mcsync_pkg.sv]
// Constants, register map and carrier types for the sync and data clock delay block.
// Assumes one sample clock drives all logic; registers are written over a simple
// register port at their printed offsets.
//
// Summary of operation
// - Programmable delay from sample clock to word clock
// - Bypass bit leaves only fixed default delay; the code uses one tap less than the fixed taps
// - Delay grows linearly, one tap per code
// - Word clock divisor from interpolation, stuffing, mode
// - Sample incoming sync on the sample clock
// - Internal sync tick period always 32 clocks
// - Input strobe at clock over interpolation factor
// - Programmable delay from tick to strobe
// - Sync timing errors latch status bit six
// - Master handles own sync like slaves
package mcsync_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_INTERFACE_CONFIG = 8'h02;
  localparam logic [7:0] ADDR_DATA_CLOCK_DELAY = 8'h04;
  localparam logic [7:0] ADDR_SYNC_RATE_SELECT = 8'h05;
  localparam logic [7:0] ADDR_SYNC_INPUT_DELAY = 8'h06;
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'h19;

  // Field positions
  localparam int DELAY_DISABLE_BIT = 4;
  localparam int DELAY_CODE_LSB = 4;
  localparam int SYNC_RATE_LSB = 1;
  localparam int SYNC_ERROR_BIT = 6;

  // Reset values
  localparam logic [7:0] RESET_INTERFACE_CONFIG = 8'h10;
  localparam logic [7:0] RESET_DATA_CLOCK_DELAY = 8'h00;
  localparam logic [7:0] RESET_SYNC_RATE_SELECT = 8'h00;
  localparam logic [7:0] RESET_SYNC_INPUT_DELAY = 8'h00;

  // ****************************************
  // Timing counts
  // ****************************************
  localparam int TICK_PERIOD = 32;
  localparam logic [5:0] SYNC_PERIOD_MAX = 6'h20;
  localparam int FIXED_DELAY_TAPS = 2;
  localparam int DELAY_LINE_TAPS = 18;

  // Interpolation factors
  typedef enum logic [1:0] {interp_1x, interp_2x, interp_4x, interp_8x} interp_e;

  // Divisor settings for the word clock
  typedef struct packed {
    interp_e interp;
    logic zero_stuff;
    logic interleaved;
  } clock_mode_s;

  // Register write request
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_req_s;

endpackage

// [src/tap_delay_line.sv]
// Shift register delay line, one tap per sample clock.
// Assumes the selected tap index stays below the depth.
`timescale 1ns/1ps
`default_nettype none
module tap_delay_line (
  input wire logic core_clk_in, // Sample clock
  input wire logic nrst_in, // Synchronous reset, active low
  input wire logic d_in, // Signal to delay
  input wire logic [4:0] tap_in, // Selected tap
  output logic q_out // Delayed signal, registered
);
  logic [mcsync_pkg::DELAY_LINE_TAPS-1:0] line;
  wire tap_bit = line[tap_in];

  // ****************************************
  // Taps
  // ****************************************
  // One flop per tap keeps steps equal
  genvar g;
  generate
    for (g = 0; g < mcsync_pkg::DELAY_LINE_TAPS; g++) begin : g_tap
      // Head tap takes the input; no index below zero is ever formed
      if (g == 0) begin : g_head
        always_ff @(posedge core_clk_in) begin
          if (!nrst_in) line[g] <= 1'b0;
          else line[g] <= d_in;
        end
      end else begin : g_body
        always_ff @(posedge core_clk_in) begin
          if (!nrst_in) line[g] <= 1'b0;
          else line[g] <= line[g-1];
        end
      end
    end
  endgenerate

  // Output straight from a flop
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) q_out <= 1'b0;
    else q_out <= tap_bit;
  end
endmodule
`default_nettype wire

// [src/multichip_sync_and_clock_delay.sv]
// Sync receiver, input-rate strobe generator and word clock delay.
// Assumes the sync input is already synchronous to the sample clock and the
// register port is written one byte per cycle.
`timescale 1ns/1ps
`default_nettype none
module multichip_sync_and_clock_delay (
  input wire logic core_clk_in, // Sample clock, 125 MHz
  input wire logic nrst_in, // Synchronous reset, active low
  input wire mcsync_pkg::reg_req_s reg_req_in, // Register write request
  input wire logic reg_rd_in, // Register read strobe
  input wire logic [7:0] reg_raddr_in, // Read address
  input wire mcsync_pkg::clock_mode_s clock_mode_in, // Word clock divisor mode
  input wire logic sync_in, // Distributed sync pulse
  output logic [7:0] reg_rdata_out, // Read data, registered
  output logic input_word_clock_out, // Delayed word clock
  output logic input_rate_strobe_out, // Aligned strobe, one cycle
  output logic sync_tick_out, // Internal sync tick, one cycle
  output logic sync_error_out // Sticky sync error flag
);
  logic [7:0] interface_config;
  logic [7:0] data_clock_delay;
  logic [7:0] sync_rate_select;
  logic [7:0] sync_input_delay;
  logic sync_prev;
  logic [5:0] tick_cnt;
  logic tick_armed;
  logic [5:0] gap_cnt;
  logic [3:0] strobe_delay_cnt;
  logic strobe_pending;
  logic [3:0] strobe_cnt;
  logic [3:0] word_cnt;
  logic word_clk_raw;

  // ****************************************
  // Register decode
  // ****************************************
  wire wr_cfg = reg_req_in.wr && reg_req_in.addr == mcsync_pkg::ADDR_INTERFACE_CONFIG;
  wire wr_dly = reg_req_in.wr && reg_req_in.addr == mcsync_pkg::ADDR_DATA_CLOCK_DELAY;
  wire wr_rate = reg_req_in.wr && reg_req_in.addr == mcsync_pkg::ADDR_SYNC_RATE_SELECT;
  wire wr_sdly = reg_req_in.wr && reg_req_in.addr == mcsync_pkg::ADDR_SYNC_INPUT_DELAY;
  wire wr_stat = reg_req_in.wr && reg_req_in.addr == mcsync_pkg::ADDR_EVENT_STATUS;
  wire clr_err = wr_stat && reg_req_in.data[mcsync_pkg::SYNC_ERROR_BIT];
  wire [7:0] status_word = {1'b0, sync_error_out, 6'h00};
  wire [7:0] next_rdata =
    (reg_raddr_in == mcsync_pkg::ADDR_INTERFACE_CONFIG) ? interface_config :
    (reg_raddr_in == mcsync_pkg::ADDR_DATA_CLOCK_DELAY) ? data_clock_delay :
    (reg_raddr_in == mcsync_pkg::ADDR_SYNC_RATE_SELECT) ? sync_rate_select :
    (reg_raddr_in == mcsync_pkg::ADDR_SYNC_INPUT_DELAY) ? sync_input_delay :
    (reg_raddr_in == mcsync_pkg::ADDR_EVENT_STATUS) ? status_word : 8'h00;

  // Register storage
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      interface_config <= mcsync_pkg::RESET_INTERFACE_CONFIG;
      data_clock_delay <= mcsync_pkg::RESET_DATA_CLOCK_DELAY;
      sync_rate_select <= mcsync_pkg::RESET_SYNC_RATE_SELECT;
      sync_input_delay <= mcsync_pkg::RESET_SYNC_INPUT_DELAY;
    end else begin
      if (wr_cfg) interface_config <= reg_req_in.data;
      if (wr_dly) data_clock_delay <= reg_req_in.data;
      if (wr_rate) sync_rate_select <= reg_req_in.data;
      if (wr_sdly) sync_input_delay <= reg_req_in.data;
    end
  end

  // Read data registered
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) reg_rdata_out <= 8'h00;
    else if (reg_rd_in) reg_rdata_out <= next_rdata;
  end

  // ****************************************
  // Sync receiver
  // ****************************************
  // Rising edge of the sampled sync; input already synchronous, master uses same path
  wire sync_rise = sync_in && !sync_prev;
  wire [2:0] rate_code = sync_rate_select[mcsync_pkg::SYNC_RATE_LSB +: 3];
  // Expected spacing of incoming pulses; undefined codes fall back to /32
  wire [5:0] expect_gap = (rate_code == 3'h1) ? 6'h10 : (rate_code == 3'h2) ? 6'h08 :
    (rate_code == 3'h3) ? 6'h04 : (rate_code == 3'h4) ? 6'h02 : mcsync_pkg::SYNC_PERIOD_MAX;
  // First edge arms the tick; later edges kept only on 32-cycle boundary
  wire keep_edge = sync_rise && (!tick_armed || tick_cnt == 6'(mcsync_pkg::TICK_PERIOD - 1));
  wire tick_due = tick_armed && tick_cnt == 6'(mcsync_pkg::TICK_PERIOD - 1);
  // Edge off the expected spacing counts as a timing error
  wire gap_bad = sync_rise && tick_armed && (gap_cnt + 6'h01) != expect_gap;

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      sync_prev <= 1'b0;
      tick_cnt <= 6'h00;
      tick_armed <= 1'b0;
      gap_cnt <= 6'h00;
      sync_tick_out <= 1'b0;
    end else begin
      sync_prev <= sync_in;
      gap_cnt <= sync_rise ? 6'h00 : gap_cnt + 6'h01;
      if (keep_edge) tick_armed <= 1'b1;
      // Free-running 32-cycle tick; extra pulses simply ignored
      tick_cnt <= (keep_edge || tick_due) ? 6'h00 : tick_cnt + 6'h01;
      sync_tick_out <= keep_edge || tick_due;
    end
  end

  // Sticky error; a new error wins over a clear
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) sync_error_out <= 1'b0;
    else if (gap_bad) sync_error_out <= 1'b1;
    else if (clr_err) sync_error_out <= 1'b0;
  end

  // ****************************************
  // Input-rate strobe
  // ****************************************
  wire [3:0] interp_max = (clock_mode_in.interp == mcsync_pkg::interp_8x) ? 4'h7 :
    (clock_mode_in.interp == mcsync_pkg::interp_4x) ? 4'h3 :
    (clock_mode_in.interp == mcsync_pkg::interp_2x) ? 4'h1 : 4'h0;
  wire [3:0] sdelay = sync_input_delay[3:0];
  // Delay done when counter reaches the programmed value
  wire realign = strobe_pending && strobe_delay_cnt == sdelay;
  wire zero_realign = sync_tick_out && sdelay == 4'h0;
  wire phase_reset = realign || zero_realign;

  // Delay from tick to strobe realignment
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      strobe_pending <= 1'b0;
      strobe_delay_cnt <= 4'h0;
    end else if (sync_tick_out && sdelay != 4'h0) begin
      strobe_pending <= 1'b1;
      strobe_delay_cnt <= 4'h1;
    end else if (realign) begin
      strobe_pending <= 1'b0;
    end else if (strobe_pending) begin
      strobe_delay_cnt <= strobe_delay_cnt + 4'h1;
    end
  end

  // Divider restarts on realignment so all devices strobe together
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      strobe_cnt <= 4'h0;
      input_rate_strobe_out <= 1'b0;
    end else begin
      strobe_cnt <= (phase_reset || strobe_cnt >= interp_max) ? 4'h0 : strobe_cnt + 4'h1;
      input_rate_strobe_out <= phase_reset || strobe_cnt >= interp_max;
    end
  end

  // ****************************************
  // Word clock and delay
  // ****************************************
  // Divisor doubles with stuffing, except for interleaved pairs, which keep the unstuffed divisor
  wire [3:0] word_half = (clock_mode_in.zero_stuff && !clock_mode_in.interleaved) ?
    interp_max : {1'b0, interp_max[3:1]};

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      word_cnt <= 4'h0;
      word_clk_raw <= 1'b0;
    end else if (phase_reset || word_cnt >= word_half) begin
      word_cnt <= 4'h0;
      word_clk_raw <= phase_reset ? 1'b1 : (interp_max == 4'h0 ? 1'b1 : !word_clk_raw);
    end else begin
      word_cnt <= word_cnt + 4'h1;
    end
  end

  // Bypass uses one tap less than the fixed taps; else fixed plus code, one tap per step
  wire bypass = interface_config[mcsync_pkg::DELAY_DISABLE_BIT];
  wire [4:0] delay_tap = bypass ? 5'(mcsync_pkg::FIXED_DELAY_TAPS - 1) :
    5'(mcsync_pkg::FIXED_DELAY_TAPS) + {1'b0, data_clock_delay[mcsync_pkg::DELAY_CODE_LSB +: 4]};

  tap_delay_line u_word_delay (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .d_in(word_clk_raw),
    .tap_in(delay_tap),
    .q_out(input_word_clock_out)
  );
endmodule
`default_nettype wire

// [verif/mcsync_sva.sv]
// Port checker for the sync receiver and word clock delay block.
// Assumes one sample clock domain; bound to the top module.
`timescale 1ns/1ps
`default_nettype none
module mcsync_sva (
  input wire logic core_clk_in, // Sample clock
  input wire logic nrst_in, // Reset, active low
  input wire mcsync_pkg::reg_req_s reg_req_in, // Write request
  input wire logic reg_rd_in, // Read strobe
  input wire logic [7:0] reg_raddr_in, // Read address
  input wire mcsync_pkg::clock_mode_s clock_mode_in, // Divisor mode
  input wire logic sync_in, // Sync pulse
  input wire logic [7:0] reg_rdata_out, // Read data
  input wire logic input_word_clock_out, // Word clock
  input wire logic input_rate_strobe_out, // Strobe
  input wire logic sync_tick_out, // Tick
  input wire logic sync_error_out // Error flag
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  logic seen;
  logic [5:0] age;
  logic [3:0] dly;
  // Decodes of the write and read ports
  wire dly_wr = reg_req_in.wr && reg_req_in.addr == mcsync_pkg::ADDR_SYNC_INPUT_DELAY;
  wire clr = reg_req_in.wr && reg_req_in.addr == mcsync_pkg::ADDR_EVENT_STATUS && reg_req_in.data[6];
  wire unmapped = !(reg_raddr_in inside {8'h02, 8'h04, 8'h05, 8'h06, 8'h19});
  // Age restarts on a delay write, since the next tick may shift the phase
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in || dly_wr) begin
      age <= 6'h00;
    end else if (seen && age != 6'h3f) begin
      age <= age + 6'h01;
    end
  end
  // Tick history and shadow of the delay field
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      seen <= 1'b0;
      dly <= 4'h0;
    end else begin
      seen <= seen | sync_tick_out;
      dly <= dly_wr ? reg_req_in.data[3:0] : dly;
    end
  end
  sequence quiet7;
    !input_rate_strobe_out [*7];
  endsequence
  sequence next_strobe;
    quiet7 ##1 input_rate_strobe_out;
  endsequence
  tick_repeat_a: assert property (sync_tick_out |-> ##32 sync_tick_out) else $error("tick not repeated");
  tick_gap_a: assert property (sync_tick_out |=> !sync_tick_out [*8]) else $error("tick too soon");
  first_tick_a: assert property ($rose(sync_in) && !seen |=> sync_tick_out) else $error("no first tick");
  strobe_align_a: assert property (sync_tick_out && dly == 4'h0 |=> input_rate_strobe_out)
    else $error("strobe late");
  strobe_rate_a: assert property (input_rate_strobe_out && age == 6'h3f
    && clock_mode_in.interp == mcsync_pkg::interp_8x |=> next_strobe) else $error("strobe rate");
  error_hold_a: assert property (sync_error_out && !clr |=> sync_error_out) else $error("error lost");
  status_read_a: assert property (reg_rd_in && reg_raddr_in == 8'h19
    |=> reg_rdata_out[6] == $past(sync_error_out)) else $error("status bit");
  unmapped_read_a: assert property (reg_rd_in && unmapped |=> reg_rdata_out == 8'h00) else $error("unmapped read");
  rdata_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out)) else $error("read data moved");
  reset_quiet_a: assert property (disable iff (1'b0) !nrst_in |=> !sync_tick_out && !sync_error_out)
    else $error("active in reset");
endmodule
bind multichip_sync_and_clock_delay mcsync_sva chk_u (.core_clk_in, .nrst_in, .reg_req_in, .reg_rd_in,
  .reg_raddr_in, .clock_mode_in, .sync_in, .reg_rdata_out, .input_word_clock_out, .input_rate_strobe_out,
  .sync_tick_out, .sync_error_out);
`default_nettype wire

// [verif/sync_source.sv]
// Model of the distributed sync source feeding the block.
// Assumes the bench sets the period and starts or stops the train.
`timescale 1ns/1ps
`default_nettype none
module sync_source (
  input wire logic core_clk_in, // Sample clock
  input wire logic run_in, // Pulse train enabled
  input wire logic [5:0] period_in, // Cycles between pulses
  output logic sync_out // Pulse to every device input
);
  logic [5:0] phase = 6'h00;
  initial sync_out = 1'b0;
  // One-cycle pulses, the shortest legal high time; one net fans out to all
  always @(posedge core_clk_in) begin
    if (!run_in) begin
      phase <= 6'h00;
      sync_out <= 1'b0;
    end else begin
      phase <= (phase == period_in - 6'h01) ? 6'h00 : phase + 6'h01;
      sync_out <= (phase == 6'h00);
    end
  end
endmodule
`default_nettype wire

// [verif/multichip_sync_and_clock_delay_tb.sv]
// Self-checking bench for the sync receiver block.
// Assumes the sync source model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module multichip_sync_and_clock_delay_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  mcsync_pkg::reg_req_s req = '0;
  logic rd = 1'b0;
  logic [7:0] raddr = 8'h00;
  mcsync_pkg::clock_mode_s mode = '{mcsync_pkg::interp_8x, 1'b0, 1'b0};
  logic run = 1'b0;
  logic [5:0] period = 6'h10;
  logic sync, strobe, tick, err, wclk;
  logic [7:0] rdata;
  int failures = 0;
  int cmp_count = 0;
  always #4 clk = ~clk;
  multichip_sync_and_clock_delay dut_u (.core_clk_in(clk), .nrst_in(nrst), .reg_req_in(req),
    .reg_rd_in(rd), .reg_raddr_in(raddr), .clock_mode_in(mode), .sync_in(sync), .reg_rdata_out(rdata),
    .input_word_clock_out(wclk), .input_rate_strobe_out(strobe), .sync_tick_out(tick), .sync_error_out(err));
  sync_source src_u (.core_clk_in(clk), .run_in(run), .period_in(period), .sync_out(sync));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{1'b1, a, d};
    @(negedge clk);
    req.wr = 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    rd = 1'b1;
    raddr = a;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask
  // Bounded wait so a dead tick cannot hang the run
  task automatic next_tick(output int n);
    n = 0;
    do begin @(negedge clk); n++; end while (tick !== 1'b1 && n < 100);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    logic [7:0] d;
    logic [7:0] a [5] = '{8'h02, 8'h04, 8'h05, 8'h06, 8'h03};
    logic [7:0] e [5] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) begin
      rdr(a[i], d);
      check("reset value", d, e[i]);
    end
    wr(8'h04, 8'hf0);
    wr(8'h03, 8'h55);
    rdr(8'h04, d);
    check("delay code", d, 8'hf0);
    rdr(8'h03, d);
    check("unmapped", d, 8'h00);
    $display("regs done");
  endtask
  task automatic t_tick;
    int n;
    wr(8'h05, 8'h02);
    run = 1'b1;
    next_tick(n);
    repeat (3) begin
      next_tick(n);
      check("tick gap", n, mcsync_pkg::TICK_PERIOD);
    end
    check("no error", err, 1'b0);
    $display("tick done");
  endtask
  task automatic t_strobe;
    int n;
    logic [3:0] d [3] = '{4'h0, 4'h5, 4'hf};
    for (int i = 0; i < 3; i++) begin
      wr(8'h06, {4'h0, d[i]});
      next_tick(n);
      next_tick(n);
      n = 0;
      do begin @(negedge clk); n++; end while (strobe !== 1'b1 && n < 20);
      check("strobe offset", n, (d[i] % 8) + 1);
    end
    $display("strobe done");
  endtask
  // Word clock edge measured from the strobe; raw word clock rises with it
  task automatic t_wclk;
    int n;
    logic p;
    logic [7:0] c [3] = '{8'h10, 8'h00, 8'h00};
    logic [7:0] k [3] = '{8'h00, 8'h00, 8'h30};
    int e [3] = '{mcsync_pkg::FIXED_DELAY_TAPS + 1, mcsync_pkg::FIXED_DELAY_TAPS + 2,
      mcsync_pkg::FIXED_DELAY_TAPS + 5};
    for (int i = 0; i < 3; i++) begin
      wr(8'h02, c[i]);
      wr(8'h04, k[i]);
      repeat (24) @(negedge clk);
      n = 0;
      do begin @(negedge clk); n++; end while (strobe !== 1'b1 && n < 20);
      n = 0;
      do begin p = wclk; @(negedge clk); n++; end while (!(wclk === 1'b1 && p === 1'b0) && n < 20);
      check("word clock delay", n, e[i]);
      n = 0;
      do begin p = wclk; @(negedge clk); n++; end while (!(wclk === 1'b1 && p === 1'b0) && n < 20);
      check("word clock period", n, 8);
    end
    $display("wclk done");
  endtask
  task automatic t_error;
    logic [7:0] d;
    int n;
    wr(8'h05, 8'h00);
    for (n = 0; n < 100 && err !== 1'b1; n++) @(negedge clk);
    rdr(8'h19, d);
    check("error bit", d[6], 1'b1);
    run = 1'b0;
    wr(8'h19, 8'h40);
    rdr(8'h19, d);
    check("error cleared", d[6], 1'b0);
    $display("error done");
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Two reset cycles suffice, every tap flop clears on each reset edge
  initial begin
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    t_regs();
    t_tick();
    t_strobe();
    t_wclk();
    t_error();
    wrap_up();
  end
  // Watchdog well past the few hundred cycles the scenarios need
  initial begin
    #40000;
    failures++;
    wrap_up();
  end
endmodule
`default_nettype wire
